// ===== core/csc_clock_source_control.sv
`timescale 1ns/1ps
`include "csc_defs.svh"

// How it works
// - Subsystem pin bit picks port or crystal
// - Oscillator register reads 00H until stable
// - Read-only flag shows high-speed oscillator stable
// - Low-speed stop bit stops low-speed oscillator
// - High-speed stop bit stops internal oscillator
// - Main stop bit resets set, gates oscillator
// - Two select bits route main, peripheral clocks
// - Read-only status shows main clock source
// - Main clock select register resets to 00H
// - Peripheral select writable once after reset
// - Low-speed consumers ignore source select bits
module csc_clock_source_control #(
    parameter int SYNC_CNT = 3
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_nrst,
    input  wire csc_pkg::csc_bus_req_t i_bus,
    output logic [7:0]                 o_rdata,
    input  wire logic                  i_cpu_on_subsys,
    input  wire logic                  i_hs_osc_ready,
    input  wire logic                  i_main_sw_ack,
    input  wire logic                  i_periph_sw_ack,
    output csc_pkg::csc_osc_en_t       o_osc,
    output csc_pkg::csc_src_sel_t      o_src,
    output logic                       o_ls_domain_en,
    output logic                       o_main_on_hs,
    output logic                       o_periph_on_hs
);

    logic [SYNC_CNT-1:0]    async_in;
    logic [SYNC_CNT-1:0]    sync_ff1;
    logic [SYNC_CNT-1:0]    sync_ff2;
    logic                   hs_ready;
    logic                   main_ack;
    logic                   periph_ack;

    // Register fields
    logic                   ext_clk_sel;
    logic                   hs_pin_mode;
    logic                   subsys_pin_mode;
    logic                   hs_stable;
    logic                   ls_osc_stop;
    logic                   hs_osc_stop;
    logic                   main_osc_stop;
    logic                   main_source_select;
    logic                   periph_source_select;
    logic                   periph_locked;
    logic                   main_req_hs;
    logic                   hs_sys_running;

    csc_pkg::csc_sw_state_t sw_state;
    csc_pkg::csc_sw_state_t next_sw_state;

    logic                   wr_clk_mode;
    logic                   wr_int_osc;
    logic                   wr_main_sel;
    logic                   wr_main_osc;
    logic [7:0]             next_rdata;

    // Register images for the read mux
    logic [7:0]             clk_mode_word;
    logic [7:0]             int_osc_word;
    logic [7:0]             main_sel_word;
    logic [7:0]             main_osc_word;

    // Reset images; every writable field resets from these
    localparam logic [7:0] RST_CLK_MODE = `CSC_RST_CLK_MODE;
    localparam logic [7:0] RST_INT_OSC  = `CSC_RST_INT_OSC;
    localparam logic [7:0] RST_MAIN_OSC = `CSC_RST_MAIN_OSC;
    localparam logic [7:0] RST_MAIN_SEL = `CSC_RST_MAIN_SEL;

    // Asynchronous oscillator and switch handshakes
    assign async_in = {i_periph_sw_ack, i_main_sw_ack, i_hs_osc_ready};

    genvar g;
    generate
        for (g = 0; g < SYNC_CNT; g++) begin : g_sync
            always_ff @(posedge i_clock or negedge i_nrst) begin
                if (!i_nrst) begin
                    sync_ff1[g] <= 1'b0;
                    sync_ff2[g] <= 1'b0;
                end else begin
                    sync_ff1[g] <= async_in[g];
                    sync_ff2[g] <= sync_ff1[g];
                end
            end
        end
    endgenerate

    assign hs_ready   = sync_ff2[0];
    assign main_ack   = sync_ff2[1];
    assign periph_ack = sync_ff2[2];

    // Write decode
    assign wr_clk_mode = i_bus.wr && (i_bus.addr == `CSC_ADDR_CLK_MODE);
    assign wr_int_osc  = i_bus.wr && (i_bus.addr == `CSC_ADDR_INT_OSC);
    assign wr_main_sel = i_bus.wr && (i_bus.addr == `CSC_ADDR_MAIN_SEL);
    assign wr_main_osc = i_bus.wr && (i_bus.addr == `CSC_ADDR_MAIN_OSC);

    // Clock operation mode register; reserved bits stay zero
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_clk_sel <= RST_CLK_MODE[`CSC_BIT_EXT_CLK];
            hs_pin_mode <= RST_CLK_MODE[`CSC_BIT_HS_PIN];
        end else if (wr_clk_mode) begin
            ext_clk_sel <= i_bus.wdata[`CSC_BIT_EXT_CLK];
            hs_pin_mode <= i_bus.wdata[`CSC_BIT_HS_PIN];
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            subsys_pin_mode <= RST_CLK_MODE[`CSC_BIT_SUBSYS_PIN];
        end else if (wr_clk_mode) begin
            subsys_pin_mode <= i_bus.wdata[`CSC_BIT_SUBSYS_PIN];
        end
    end

    // Internal oscillator stop bits
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ls_osc_stop <= RST_INT_OSC[`CSC_BIT_LS_STOP];
        end else if (wr_int_osc) begin
            ls_osc_stop <= i_bus.wdata[`CSC_BIT_LS_STOP];
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            hs_osc_stop <= RST_INT_OSC[`CSC_BIT_HS_STOP];
        end else if (wr_int_osc) begin
            hs_osc_stop <= i_bus.wdata[`CSC_BIT_HS_STOP];
        end
    end

    // Stability flag: clear after reset, set by hardware only, never by a write
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            hs_stable <= 1'b0;
        end else begin
            hs_stable <= hs_ready && !hs_osc_stop;
        end
    end

    // Main oscillator stop bit
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            main_osc_stop <= RST_MAIN_OSC[`CSC_BIT_MAIN_STOP];
        end else if (wr_main_osc) begin
            main_osc_stop <= i_bus.wdata[`CSC_BIT_MAIN_STOP];
        end
    end

    // Main source select is freely writable
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            main_source_select <= RST_MAIN_SEL[`CSC_BIT_MAIN_SEL];
        end else if (wr_main_sel) begin
            main_source_select <= i_bus.wdata[`CSC_BIT_MAIN_SEL];
        end
    end

    // Peripheral select accepts the first write after reset only
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            periph_source_select <= RST_MAIN_SEL[`CSC_BIT_PERIPH_SEL];
        end else if (wr_main_sel && !periph_locked) begin
            periph_source_select <= i_bus.wdata[`CSC_BIT_PERIPH_SEL];
        end
    end

    // Any write to the select register uses up the one chance
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            periph_locked <= 1'b0;
        end else if (wr_main_sel) begin
            periph_locked <= 1'b1;
        end
    end

    // High-speed system clock present only in oscillator or external mode
    assign hs_sys_running = hs_pin_mode && !main_osc_stop;

    // Main clock takes the high-speed system clock only for selection 11
    assign main_req_hs = periph_source_select && main_source_select;

    // Main source switch waits for the external glitch-free cell to confirm
    always_comb begin
        next_sw_state = sw_state;
        unique case (sw_state)
            csc_pkg::SW_INT: begin
                if (main_req_hs && hs_sys_running) begin
                    next_sw_state = csc_pkg::SW_TO_HS;
                end
            end
            csc_pkg::SW_TO_HS: begin
                if (main_ack) begin
                    next_sw_state = csc_pkg::SW_HS;
                end
            end
            csc_pkg::SW_HS: begin
                if (!main_req_hs) begin
                    next_sw_state = csc_pkg::SW_TO_INT;
                end
            end
            csc_pkg::SW_TO_INT: begin
                if (!main_ack) begin
                    next_sw_state = csc_pkg::SW_INT;
                end
            end
        endcase
    end

    // Switch sequencer state
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sw_state <= csc_pkg::SW_INT;
        end else begin
            sw_state <= next_sw_state;
        end
    end

    // Oscillator enables
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_osc <= '0;
        end else begin
            o_osc.hs_int      <= !hs_osc_stop;
            o_osc.ls_int      <= !ls_osc_stop;
            o_osc.main_xtal   <= hs_sys_running && !ext_clk_sel;
            o_osc.main_ext    <= hs_sys_running && ext_clk_sel;
            o_osc.subsys_xtal <= subsys_pin_mode;
        end
    end

    // Main source request follows the switch sequencer; peripheral request follows the raw select
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_src <= '0;
        end else begin
            o_src.main_hs   <= (next_sw_state == csc_pkg::SW_TO_HS)
                            || (next_sw_state == csc_pkg::SW_HS);
            o_src.periph_hs <= periph_source_select;
        end
    end

    // Low-speed consumers stay off the source select path
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ls_domain_en <= 1'b0;
        end else begin
            o_ls_domain_en <= !ls_osc_stop;
        end
    end

    // Status shows the clock actually in use, not the request
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_main_on_hs <= 1'b0;
        end else begin
            o_main_on_hs <= (sw_state == csc_pkg::SW_HS)
                         || (sw_state == csc_pkg::SW_TO_INT);
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_periph_on_hs <= 1'b0;
        end else begin
            o_periph_on_hs <= periph_ack;
        end
    end

    // Register images; reserved bits read zero
    always_comb begin
        clk_mode_word                      = 8'h00;
        clk_mode_word[`CSC_BIT_EXT_CLK]    = ext_clk_sel;
        clk_mode_word[`CSC_BIT_HS_PIN]     = hs_pin_mode;
        clk_mode_word[`CSC_BIT_SUBSYS_PIN] = subsys_pin_mode;
    end

    always_comb begin
        int_osc_word                     = 8'h00;
        int_osc_word[`CSC_BIT_HS_STABLE] = hs_stable;
        int_osc_word[`CSC_BIT_LS_STOP]   = ls_osc_stop;
        int_osc_word[`CSC_BIT_HS_STOP]   = hs_osc_stop;
    end

    always_comb begin
        main_sel_word                      = 8'h00;
        main_sel_word[`CSC_BIT_PERIPH_SEL] = periph_source_select;
        main_sel_word[`CSC_BIT_MAIN_STAT]  = o_main_on_hs;
        main_sel_word[`CSC_BIT_MAIN_SEL]   = main_source_select;
    end

    always_comb begin
        main_osc_word                     = 8'h00;
        main_osc_word[`CSC_BIT_MAIN_STOP] = main_osc_stop;
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        unique case (i_bus.addr)
            `CSC_ADDR_CLK_MODE: begin
                next_rdata = clk_mode_word;
            end
            `CSC_ADDR_INT_OSC: begin
                next_rdata = int_osc_word;
            end
            `CSC_ADDR_MAIN_SEL: begin
                next_rdata = main_sel_word;
            end
            `CSC_ADDR_MAIN_OSC: begin
                next_rdata = main_osc_word;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // Read data stands for the one cycle after the strobe only
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
        end else if (i_bus.rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule : csc_clock_source_control

// ===== core/csc_defs.svh
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

// Register addresses
`define CSC_ADDR_CLK_MODE   16'hff9f
`define CSC_ADDR_INT_OSC    16'hffa0
`define CSC_ADDR_MAIN_SEL   16'hffa1
`define CSC_ADDR_MAIN_OSC   16'hffa2

// Clock operation mode register fields
`define CSC_BIT_EXT_CLK     7
`define CSC_BIT_HS_PIN      6
`define CSC_BIT_SUBSYS_PIN  4
`define CSC_RST_CLK_MODE    8'h00

// Internal oscillation mode register fields
`define CSC_BIT_HS_STABLE   7
`define CSC_BIT_LS_STOP     1
`define CSC_BIT_HS_STOP     0
`define CSC_RST_INT_OSC     8'h80

// Main oscillator control register fields
`define CSC_BIT_MAIN_STOP   7
`define CSC_RST_MAIN_OSC    8'h80

// Main clock select register fields
`define CSC_BIT_PERIPH_SEL  2
`define CSC_BIT_MAIN_STAT   1
`define CSC_BIT_MAIN_SEL    0
`define CSC_RST_MAIN_SEL    8'h00

`endif

// ===== core/csc_pkg.sv
package csc_pkg;

    typedef struct packed {
        logic hs_int;
        logic ls_int;
        logic main_xtal;
        logic main_ext;
        logic subsys_xtal;
    } csc_osc_en_t;

    typedef struct packed {
        logic main_hs;
        logic periph_hs;
    } csc_src_sel_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } csc_bus_req_t;

    typedef enum logic [1:0] {
        SW_INT    = 2'b00,
        SW_TO_HS  = 2'b01,
        SW_HS     = 2'b10,
        SW_TO_INT = 2'b11
    } csc_sw_state_t;

endpackage : csc_pkg

// ===== tb/csc_clock_source_control_tb_top.sv
`timescale 1ns/1ps
module csc_clock_source_control_tb_top;
    logic                  clk;
    logic                  nrst;
    csc_pkg::csc_bus_req_t bus;
    logic [7:0]            rdata;
    logic                  rdy;
    logic                  m_ack;
    logic                  p_ack;
    csc_pkg::csc_osc_en_t  osc;
    csc_pkg::csc_src_sel_t src;
    logic                  ls_en;
    logic                  m_on;
    logic                  p_on;
    logic                  cpu_sub;
    logic                  s;
    logic [7:0]            d;
    int                    n_errors;
    int                    check_count;
    int                    cycles;
    int                    seed;
    int                    i;

    csc_clock_source_control u_csc_clock_source_control (
        .i_clock(clk), .i_nrst(nrst), .i_bus(bus), .o_rdata(rdata),
        .i_cpu_on_subsys(cpu_sub), .i_hs_osc_ready(rdy), .i_main_sw_ack(m_ack),
        .i_periph_sw_ack(p_ack), .o_osc(osc), .o_src(src), .o_ls_domain_en(ls_en),
        .o_main_on_hs(m_on), .o_periph_on_hs(p_on));
    csc_osc_model u_csc_osc_model (
        .i_clock(clk), .i_nrst(nrst), .i_osc(osc), .i_src(src),
        .o_hs_ready(rdy), .o_main_ack(m_ack), .o_periph_ack(p_ack));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            end_of_test();
        end
    end

    function automatic logic [7:0] exp_osc(input logic [7:0] m, input logic [7:0] r,
                                           input logic st);
        exp_osc = {3'h0, !r[0], !r[1], m[6] & !st & !m[7], m[6] & !st & m[7], m[4]};
    endfunction : exp_osc
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        bus.addr  <= a;
        bus.wdata <= v;
        bus.wr    <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task automatic wait_main(input logic v);
        for (int k = 0; k < 64 && m_on !== v; k++) wt(1);
        #1 chk("main_on", {7'h0, v}, {7'h0, m_on});
    endtask : wait_main
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        clk = 0;
        nrst = 0;
        bus = '0;
        cpu_sub = 1'b0;
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        seed = 32'h0605;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(16'hffa0, 8'h00);
        rd(16'hff9f, 8'h00);
        rd(16'hffa2, 8'h80);
        rd(16'hffa1, 8'h00);
        wr(16'hffa5, 8'hff);
        rd(16'hffa5, 8'h00);
        wt(30);
        rd(16'hffa0, 8'h80);
        $display("test reset_values done");
        wr(16'hff9f, 8'h10);
        cpu_sub <= 1'b1;
        for (i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            d[1:0] = i[1:0];
            wr(16'hffa0, d);
            wt(8);
            chk("osc", exp_osc(8'h10, d, 1'b1), {3'h0, osc});
            chk("ls_dom", {7'h0, !d[1]}, {7'h0, ls_en});
            rd(16'hffa0, {!d[0], 5'h00, d[1:0]});
            wr(16'hffa0, 8'h00);
            wt(30);
        end
        @(posedge clk);
        cpu_sub <= 1'b0;
        $display("test int_osc done");
        for (i = 0; i < 16; i++) begin
            d = {i[2], i[1], 1'b0, i[0], 4'h0};
            s = i[3] | !i[1];
            wr(16'hffa2, 8'h80);
            wr(16'hff9f, d);
            wr(16'hffa2, {s, 7'h00});
            wt(3);
            chk("osc", exp_osc(d, 8'h00, s), {3'h0, osc});
            rd(16'hff9f, d);
            rd(16'hffa2, {s, 7'h00});
        end
        $display("test pin_modes done");
        wr(16'hffa2, 8'h80);
        wr(16'hff9f, 8'h40);
        wr(16'hffa2, 8'h00);
        wr(16'hffa1, 8'h07);
        wt(3);
        chk("periph_sel", 8'h01, {7'h0, src.periph_hs});
        wait_main(1'b1);
        rd(16'hffa1, 8'h07);
        chk("periph_on", 8'h01, {7'h0, p_on});
        wr(16'hffa1, 8'h00);
        wt(3);
        chk("main_req", 8'h00, {7'h0, src.main_hs});
        wait_main(1'b0);
        rd(16'hffa1, 8'h04);
        $display("test switch done");
        @(posedge clk);
        nrst <= 1'b0;
        wt(4);
        nrst <= 1'b1;
        wr(16'hff9f, 8'h40);
        wr(16'hffa2, 8'h00);
        wr(16'hffa1, 8'h01);
        wt(3);
        chk("main_req01", 8'h00, {7'h0, src.main_hs});
        wr(16'hffa1, 8'h05);
        wt(3);
        chk("periph_lock", 8'h00, {7'h0, src.periph_hs});
        rd(16'hffa1, 8'h01);
        $display("test periph_lock done");
        end_of_test();
    end
endmodule : csc_clock_source_control_tb_top

// ===== tb/csc_osc_model.sv
`timescale 1ns/1ps
module csc_osc_model #(
    parameter int DLY = 20
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_nrst,
    input  wire csc_pkg::csc_osc_en_t  i_osc,
    input  wire csc_pkg::csc_src_sel_t i_src,
    output logic                       o_hs_ready,
    output logic                       o_main_ack,
    output logic                       o_periph_ack
);
    logic [7:0] cnt;
    logic [3:0] m_sh;
    logic [3:0] p_sh;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt  <= 8'h00;
            m_sh <= 4'h0;
            p_sh <= 4'h0;
        end else begin
            cnt  <= !i_osc.hs_int ? 8'h00 : (cnt < DLY) ? cnt + 8'h01 : cnt;
            // Main switch only completes while the high-speed clock runs; peripheral switch always completes
            m_sh <= {m_sh[2:0], i_src.main_hs & (i_osc.main_xtal | i_osc.main_ext)};
            p_sh <= {p_sh[2:0], i_src.periph_hs};
        end
    end
    assign o_hs_ready   = (cnt >= DLY);
    assign o_main_ack   = m_sh[3];
    assign o_periph_ack = p_sh[3];
endmodule : csc_osc_model

// ===== tb/csc_props.sv
`timescale 1ns/1ps
module csc_props #(
    parameter int SYNC_CNT = 3
) (
    input wire logic                  i_clock,
    input wire logic                  i_nrst,
    input wire csc_pkg::csc_bus_req_t i_bus,
    input wire logic [7:0]            o_rdata,
    input wire logic                  i_hs_osc_ready,
    input wire logic                  i_main_sw_ack,
    input wire logic                  i_periph_sw_ack,
    input wire csc_pkg::csc_osc_en_t  o_osc,
    input wire csc_pkg::csc_src_sel_t o_src,
    input wire logic                  o_ls_domain_en,
    input wire logic                  o_main_on_hs,
    input wire logic                  o_periph_on_hs
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);
    sequence s_wr(a);
        i_bus.wr && i_bus.addr == a;
    endsequence
    sequence s_rd_osc;
        i_bus.rd && i_bus.addr == 16'hffa0;
    endsequence
    a_rdata_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
        else $error("rdata idle");
    a_hs_enable: assert property (s_wr(16'hffa0) |=> ##1 o_osc.hs_int == !$past(i_bus.wdata[0], 2))
        else $error("hs enable");
    a_ls_enable: assert property (s_wr(16'hffa0) |=> ##1 o_osc.ls_int == !$past(i_bus.wdata[1], 2))
        else $error("ls enable");
    a_ls_domain: assert property (o_ls_domain_en == o_osc.ls_int)
        else $error("ls domain");
    a_subsys_pin: assert property (s_wr(16'hff9f) |=> ##1 o_osc.subsys_xtal == $past(i_bus.wdata[4], 2))
        else $error("subsys pin");
    a_main_stop: assert property (s_wr(16'hffa2) ##0 i_bus.wdata[7] |=> ##1 !(o_osc.main_xtal || o_osc.main_ext))
        else $error("main stop");
    a_stable_wait: assert property (!i_hs_osc_ready [*4] ##0 s_rd_osc |=> !o_rdata[7])
        else $error("stable flag");
    a_osc_rsvd: assert property (s_rd_osc |=> o_rdata[6:2] == 5'h00)
        else $error("reserved bits");
    a_main_rise: assert property ($rose(o_main_on_hs) |-> $past(i_main_sw_ack, 4))
        else $error("main status rise");
    a_main_fall: assert property ($fell(o_main_on_hs) |-> !$past(i_main_sw_ack, 4))
        else $error("main status fall");
    a_periph_rise: assert property ($rose(o_periph_on_hs) |-> $past(i_periph_sw_ack, 3))
        else $error("periph status");
endmodule : csc_props
bind csc_clock_source_control csc_props #(.SYNC_CNT(SYNC_CNT)) u_csc_props (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_hs_osc_ready(i_hs_osc_ready), .i_main_sw_ack(i_main_sw_ack),
    .i_periph_sw_ack(i_periph_sw_ack), .o_osc(o_osc), .o_src(o_src),
    .o_ls_domain_en(o_ls_domain_en), .o_main_on_hs(o_main_on_hs),
    .o_periph_on_hs(o_periph_on_hs));
